//--- src/pump_supervisor.sv
/*
 * Sleep, overpressure and automatic restart supervisor of a constant
 * pressure pump drive, with an APB register slave and one interrupt.
 * Assumes pressure and motor_speed are words from logic on sys_clk;
 * fault, keypad, run demand and power pins are asynchronous.
 */
// Functional notes
// - Sleep is allowed only while pressure has reached the target.
// - Sleep needs speed below sleep offset plus lowest run speed.
// - Sleep needs run time since the last restart above the chosen min on-time.
// - Pressure above target plus excess offset stops the pump at once.
// - A zero sleep offset disables sleep and keeps the motor running.
// - Restarts off means init in off mode and no restart after a fault.
// - Dry well trips only after persisting for its delay in seconds.
// - A trip waits a per-category restart delay before restarting.
// - Restarts are limited by configured counts for fault causes 0, 1, 2, 4, 6 and 7; causes 3 and 5 are not counted.
// - A power off/on cycle waits the start-up delay before running.
// - Restarts after sensor signal loss are limited by their count.
// - Every run command waits the short-cycle delay, shown as seconds left, unless up and down keys together abort it.
// - Restart counters hold until a clear-memory command zeroes them.
// - Up and down keys together abort a running countdown.
// - Sleep and overpressure act only in analog constant pressure mode.
module pump_supervisor #(
   parameter int unsigned TICK_CYCLES = sup_pkg::TICK_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] pressure,
   input  wire logic [15:0] motor_speed,
   input  wire logic [7:0]  fault_in,
   input  wire logic        run_demand,
   input  wire logic        key_up,
   input  wire logic        key_down,
   input  wire logic        power_ok,
   output logic             motor_run,
   output logic             sleeping,
   output logic             fault_hold,
   output logic [13:0]      countdown,
   output logic             irq
);
   typedef struct packed {
      sup_pkg::state_t  st;
      logic             auto_m;
      logic             tick;
      logic [25:0]      div;
      logic [11:0]      s1;
      logic [11:0]      s2;
      logic             pwr_prev;
      logic             en_rst;
      logic             on_sel;
      logic [2:0]       cfg;
      logic [15:0]      tgt;
      logic [15:0]      xoff;
      logic [15:0]      minspd;
      logic [15:0]      soff;
      logic [13:0]      t1;
      logic [13:0]      t2;
      logic [13:0]      dwd;
      logic [13:0]      sud;
      logic [8:0]       scd;
      logic [2:0][13:0] rd;
      logic [5:0][13:0] lim;
      logic [5:0][13:0] rc;
      logic [13:0]      cnt;
      logic [13:0]      ontime;
      logic [13:0]      dwc;
      logic [3:0]       ist;
      logic [3:0]       imsk;
      logic [31:0]      rdata;
   } regs_t;

   regs_t r;
   regs_t n;
   logic        wr;
   logic        run_w;
   logic        stop_w;
   logic        clr_w;
   logic        abort;
   logic        cp;
   logic        overp;
   logic        sleep_ok;
   logic        hit;
   logic        mapped;
   logic [7:0]  fq;
   logic [2:0]  cause;
   logic [2:0]  cidx;
   logic [13:0] dly;
   logic [3:0]  iset;
   logic [31:0] mux;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      mux    = 32'h0000_0000;
      unique case (paddr)
         sup_pkg::A_CTRL:   mux = {27'h0, r.cfg, r.on_sel, r.en_rst};
         sup_pkg::A_PRESS:  mux = {r.xoff, r.tgt};
         sup_pkg::A_SPEED:  mux = {r.soff, r.minspd};
         sup_pkg::A_ONTIME: mux = {2'h0, r.t2, 2'h0, r.t1};
         sup_pkg::A_DLY0:   mux = {2'h0, r.rd[0], 2'h0, r.dwd};
         sup_pkg::A_DLY1:   mux = {2'h0, r.rd[2], 2'h0, r.rd[1]};
         sup_pkg::A_DLY2:   mux = {7'h0, r.scd, 2'h0, r.sud};
         sup_pkg::A_LIM0:   mux = {2'h0, r.lim[1], 2'h0, r.lim[0]};
         sup_pkg::A_LIM1:   mux = {2'h0, r.lim[3], 2'h0, r.lim[2]};
         sup_pkg::A_LIM2:   mux = {2'h0, r.lim[5], 2'h0, r.lim[4]};
         sup_pkg::A_STATUS: mux = {10'h0, r.cnt, r.auto_m, r.st};
         sup_pkg::A_ISTAT:  mux = {28'h0, r.ist};
         sup_pkg::A_IMASK:  mux = {28'h0, r.imsk};
         default:           mapped = 1'b0;
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr      = psel & penable & pwrite & mapped;
   assign run_w   = wr && paddr == sup_pkg::A_CTRL && pwdata[sup_pkg::F_RUN];
   assign stop_w  = wr && paddr == sup_pkg::A_CTRL && pwdata[sup_pkg::F_STOP];
   assign clr_w   = wr && paddr == sup_pkg::A_CTRL && pwdata[sup_pkg::F_CLR];

   // ---------------------------------------------------------------
   // Supervision terms
   // ---------------------------------------------------------------
   assign abort = r.s2[9] & r.s2[10];
   assign cp    = r.cfg == sup_pkg::CFG_CP;
   // Sums are one bit wider so a large offset cannot wrap
   assign overp = cp && {1'b0, pressure} > {1'b0, r.tgt} + {1'b0, r.xoff};
   assign sleep_ok = cp && r.soff != 16'h0000
                  && pressure >= r.tgt
                  && {1'b0, motor_speed} < {1'b0, r.soff} + {1'b0, r.minspd}
                  && r.ontime > (r.on_sel ? r.t2 : r.t1);
   // Dry well is qualified by its persistence counter
   assign fq = {r.s2[7:3], r.s2[2] && r.dwc >= r.dwd, r.s2[1:0]};
   assign hit = r.st == sup_pkg::S_RUN && fq != 8'h00;

   // Lowest fault bit wins; it picks delay category and counter
   always_comb begin
      cause = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (fq[i]) begin
            cause = 3'(i);
         end
      end
      unique case (cause)
         3'h0:    dly = r.rd[0];
         3'h1, 3'h2, 3'h3, 3'h4: dly = r.rd[1];
         default: dly = r.rd[2];
      endcase
      unique case (cause)
         3'h0:    cidx = 3'h0;
         3'h2:    cidx = 3'h1;
         3'h6:    cidx = 3'h2;
         3'h7:    cidx = 3'h3;
         3'h1:    cidx = 3'h4;
         3'h4:    cidx = 3'h5;
         default: cidx = sup_pkg::NO_CNT;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n      = r;
      iset   = 4'h0;
      n.s1   = {power_ok, key_down, key_up, run_demand, fault_in};
      n.s2   = r.s1;
      n.pwr_prev = r.s2[11];
      n.tick = r.div == 26'(TICK_CYCLES - 1);
      n.div  = n.tick ? 26'h0 : r.div + 26'h1;
      if (psel && !penable && !pwrite) begin
         n.rdata = mux;
      end
      if (wr) begin
         unique case (paddr)
            sup_pkg::A_CTRL: begin
               n.en_rst = pwdata[sup_pkg::F_EN];
               n.on_sel = pwdata[sup_pkg::F_SEL];
               n.cfg    = pwdata[sup_pkg::F_CFG +: 3];
            end
            sup_pkg::A_PRESS: {n.xoff, n.tgt} = pwdata;
            sup_pkg::A_SPEED: {n.soff, n.minspd} = pwdata;
            sup_pkg::A_ONTIME: begin
               n.t1 = pwdata[13:0];
               n.t2 = pwdata[sup_pkg::F_HI +: 14];
            end
            sup_pkg::A_DLY0: begin
               n.dwd   = pwdata[13:0];
               n.rd[0] = pwdata[sup_pkg::F_HI +: 14];
            end
            sup_pkg::A_DLY1: begin
               n.rd[1] = pwdata[13:0];
               n.rd[2] = pwdata[sup_pkg::F_HI +: 14];
            end
            sup_pkg::A_DLY2: begin
               n.sud = pwdata[13:0];
               n.scd = pwdata[sup_pkg::F_HI +: 9];
            end
            sup_pkg::A_LIM0: {n.lim[1], n.lim[0]} = {pwdata[29:16], pwdata[13:0]};
            sup_pkg::A_LIM1: {n.lim[3], n.lim[2]} = {pwdata[29:16], pwdata[13:0]};
            sup_pkg::A_LIM2: {n.lim[5], n.lim[4]} = {pwdata[29:16], pwdata[13:0]};
            sup_pkg::A_IMASK: n.imsk = pwdata[3:0];
            default: ;
         endcase
      end
      // Persistence of the dry well input in whole seconds
      if (!r.s2[2]) begin
         n.dwc = 14'h0;
      end else if (r.tick && r.dwc != 14'h3FFF) begin
         n.dwc = r.dwc + 14'h1;
      end
      if (r.st == sup_pkg::S_RUN && r.tick && r.ontime != 14'h3FFF) begin
         n.ontime = r.ontime + 14'h1;
      end
      if (r.tick && r.cnt != 14'h0) begin
         n.cnt = r.cnt - 14'h1;
      end
      if (abort && r.st inside {sup_pkg::S_START, sup_pkg::S_SHORT, sup_pkg::S_TRIP}) begin
         n.cnt = 14'h0;
      end
      unique case (r.st)
         sup_pkg::S_OFF: begin
            if (run_w || (r.auto_m && r.s2[8])) begin
               n.st  = sup_pkg::S_SHORT;
               n.cnt = {5'h0, r.scd};
            end
         end
         sup_pkg::S_START: begin
            if (!r.en_rst) begin
               n.st = sup_pkg::S_OFF;
               n.auto_m = 1'b0;
            end else if (r.cnt == 14'h0 && !abort) begin
               n.st  = sup_pkg::S_SHORT;
               n.cnt = {5'h0, r.scd};
            end
         end
         sup_pkg::S_SHORT: begin
            if (r.cnt == 14'h0) begin
               n.st = sup_pkg::S_RUN;
               n.ontime = 14'h0;
            end
         end
         sup_pkg::S_RUN: begin
            if (hit) begin
               iset[sup_pkg::I_TRIP] = 1'b1;
               if (!r.en_rst || (cidx != sup_pkg::NO_CNT && r.rc[cidx] >= r.lim[cidx])) begin
                  n.st = sup_pkg::S_LOCK;
                  iset[sup_pkg::I_LOCK] = 1'b1;
               end else begin
                  n.st  = sup_pkg::S_TRIP;
                  n.cnt = dly;
                  if (cidx != sup_pkg::NO_CNT) begin
                     n.rc[cidx] = r.rc[cidx] + 14'h1;
                  end
               end
            end else if (overp) begin
               n.st = sup_pkg::S_SLEEP;
               iset[sup_pkg::I_OVP] = 1'b1;
               iset[sup_pkg::I_SLP] = 1'b1;
            end else if (sleep_ok) begin
               n.st = sup_pkg::S_SLEEP;
               iset[sup_pkg::I_SLP] = 1'b1;
            end else if (r.auto_m && !r.s2[8]) begin
               n.st = sup_pkg::S_OFF;
            end
         end
         sup_pkg::S_SLEEP: begin
            if (!cp || (pressure < r.tgt && r.auto_m)) begin
               n.st  = sup_pkg::S_SHORT;
               n.cnt = {5'h0, r.scd};
            end
         end
         sup_pkg::S_TRIP: begin
            if (r.cnt == 14'h0 && !abort) begin
               n.st  = sup_pkg::S_SHORT;
               n.cnt = {5'h0, r.scd};
            end
         end
         sup_pkg::S_LOCK: begin
            if (clr_w) begin
               n.st = sup_pkg::S_OFF;
            end
         end
      endcase
      if (clr_w) begin
         n.rc = '0;
      end
      if (stop_w) begin
         n.st = sup_pkg::S_OFF;
         n.auto_m = 1'b0;
      end
      if (r.s2[11] && !r.pwr_prev) begin
         n.st  = sup_pkg::S_START;
         n.cnt = r.sud;
         n.auto_m = r.en_rst;
      end
      // Set wins over a write-one clear in the same cycle
      n.ist = r.ist & ~((wr && paddr == sup_pkg::A_ISTAT) ? pwdata[3:0] : 4'h0) | iset;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         r        <= '0;
         r.st     <= sup_pkg::S_START;
         r.auto_m <= 1'b1;
         r.en_rst <= 1'b1;
         r.cfg    <= sup_pkg::DEF_CFG;
         r.tgt    <= sup_pkg::DEF_TGT;
         r.xoff   <= sup_pkg::DEF_XOFF;
         r.minspd <= sup_pkg::DEF_MIN;
         r.soff   <= sup_pkg::DEF_SOFF;
         r.t1     <= sup_pkg::DEF_TON;
         r.t2     <= sup_pkg::DEF_TON;
         r.dwd    <= sup_pkg::DEF_DWD;
         r.sud    <= sup_pkg::DEF_SUD;
         r.scd    <= sup_pkg::DEF_SCD;
         r.rd     <= {sup_pkg::DEF_RD3, sup_pkg::DEF_RD2, sup_pkg::DEF_RD1};
         r.lim    <= {{5{sup_pkg::DEF_LIM}}, sup_pkg::DEF_LOL};
         r.cnt    <= sup_pkg::DEF_SUD;
         // Power sync starts high so leaving reset is not a power cycle
         r.s1[11]   <= 1'b1;
         r.s2[11]   <= 1'b1;
         r.pwr_prev <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign prdata     = r.rdata;
   assign motor_run  = r.st == sup_pkg::S_RUN;
   assign sleeping   = r.st == sup_pkg::S_SLEEP;
   assign fault_hold = r.st inside {sup_pkg::S_TRIP, sup_pkg::S_LOCK};
   assign countdown  = r.cnt;
   assign irq        = |(r.ist & r.imsk);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_sleep_press: assert property (
      r.st == sup_pkg::S_RUN && n.st == sup_pkg::S_SLEEP && !overp |-> pressure >= r.tgt)
      else $error("sleep entered below target pressure");
   a_sleep_speed: assert property (
      r.st == sup_pkg::S_RUN && n.st == sup_pkg::S_SLEEP && !overp
      |-> {1'b0, motor_speed} < {1'b0, r.soff} + {1'b0, r.minspd})
      else $error("sleep entered above speed limit");
   a_sleep_ontime: assert property (
      $rose(sleeping) && !$past(overp) |-> $past(r.ontime) > $past(r.on_sel ? r.t2 : r.t1))
      else $error("sleep entered before min on-time");
   a_overp_stop: assert property (
      motor_run && overp && fq == 8'h00 && !stop_w && !(r.s2[11] && !r.pwr_prev)
      |=> sleeping ##1 !motor_run)
      else $error("overpressure did not stop pump");
   a_zero_offset: assert property (
      motor_run && r.soff == 16'h0000 && !overp |=> !sleeping)
      else $error("sleep entered with zero offset");
   a_no_restart: assert property (
      hit && !r.en_rst && !stop_w |=> r.st == sup_pkg::S_LOCK)
      else $error("fault restart while restarts disabled");
   a_trip_delay: assert property (
      hit && r.st == sup_pkg::S_RUN && !stop_w && !(r.s2[11] && !r.pwr_prev)
      && n.st == sup_pkg::S_TRIP |=> r.cnt == $past(dly))
      else $error("trip delay not reloaded");
   a_short_hold: assert property (
      r.st == sup_pkg::S_SHORT && r.cnt > 14'h1 && !abort && !stop_w
      && !(r.s2[11] && !r.pwr_prev) |=> r.st == sup_pkg::S_SHORT [*2])
      else $error("motor engaged before short-cycle delay");
   a_clear_mem: assert property (
      clr_w |=> r.rc == '0)
      else $error("clear memory left counters set");
   a_key_abort: assert property (
      abort && r.st == sup_pkg::S_TRIP |=> r.cnt == 14'h0)
      else $error("keys did not abort countdown");
   a_cp_only: assert property (
      !cp && motor_run |=> !sleeping)
      else $error("sleep outside constant pressure mode");
   a_lock_hold: assert property (
      r.st == sup_pkg::S_LOCK && !clr_w && !stop_w && !(r.s2[11] && !r.pwr_prev)
      |=> r.st == sup_pkg::S_LOCK)
      else $error("locked fault left without clear");
endmodule

//--- src/sup_pkg.sv
/*
 * Constants, register map and state codes of the pump sleep and restart
 * supervisor. Assumes a 50 MHz system clock and a 32-bit APB bus.
 */
package sup_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS   = 20;
   localparam int SEC_NS   = 1_000_000_000;
   localparam int TICK_CYC = SEC_NS / CLK_NS;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_PRESS  = 8'h04;
   localparam logic [7:0] A_SPEED  = 8'h08;
   localparam logic [7:0] A_ONTIME = 8'h0C;
   localparam logic [7:0] A_DLY0   = 8'h10;
   localparam logic [7:0] A_DLY1   = 8'h14;
   localparam logic [7:0] A_DLY2   = 8'h18;
   localparam logic [7:0] A_LIM0   = 8'h1C;
   localparam logic [7:0] A_LIM1   = 8'h20;
   localparam logic [7:0] A_LIM2   = 8'h24;
   localparam logic [7:0] A_STATUS = 8'h28;
   localparam logic [7:0] A_ISTAT  = 8'h2C;
   localparam logic [7:0] A_IMASK  = 8'h30;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int F_EN   = 0;
   localparam int F_SEL  = 1;
   localparam int F_CFG  = 2;
   localparam int F_RUN  = 8;
   localparam int F_STOP = 9;
   localparam int F_CLR  = 10;
   localparam int F_HI   = 16;
   localparam int F_AUTO = 7;
   localparam int F_CNT  = 8;
   localparam int I_TRIP = 0;
   localparam int I_LOCK = 1;
   localparam int I_SLP  = 2;
   localparam int I_OVP  = 3;

   // ---------------------------------------------------------------
   // Values after reset and fixed codes
   // ---------------------------------------------------------------
   localparam logic [2:0]  CFG_CP   = 3'h1;
   localparam logic [2:0]  DEF_CFG  = 3'h0;
   localparam logic [15:0] DEF_TGT  = 16'h0032;
   localparam logic [15:0] DEF_XOFF = 16'h0014;
   localparam logic [15:0] DEF_MIN  = 16'h001E;
   localparam logic [15:0] DEF_SOFF = 16'h000A;
   localparam logic [13:0] DEF_TON  = 14'h001E;
   localparam logic [13:0] DEF_DWD  = 14'h0004;
   localparam logic [13:0] DEF_RD1  = 14'h003C;
   localparam logic [13:0] DEF_RD2  = 14'h000F;
   localparam logic [13:0] DEF_RD3  = 14'h000F;
   localparam logic [13:0] DEF_LOL  = 14'h0004;
   localparam logic [13:0] DEF_LIM  = 14'h000A;
   localparam logic [13:0] DEF_SUD  = 14'h0000;
   localparam logic [8:0]  DEF_SCD  = 9'h003;
   localparam logic [2:0]  NO_CNT   = 3'h7;

   typedef enum logic [6:0] {
      S_OFF   = 7'h01,
      S_START = 7'h02,
      S_SHORT = 7'h04,
      S_RUN   = 7'h08,
      S_SLEEP = 7'h10,
      S_TRIP  = 7'h20,
      S_LOCK  = 7'h40
   } state_t;
endpackage

//--- verif/pump_plant.sv
/*
 * Behavioural model of the motor drive stage and the pressure sensor.
 * Assumes the bench commands the pressure, the speed while running and
 * the fault levels; all are registered on sys_clk.
 */
module pump_plant (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        motor_run,
   input  wire logic [15:0] set_press,
   input  wire logic [15:0] set_speed,
   input  wire logic [7:0]  set_fault,
   output logic [15:0]      pressure,
   output logic [15:0]      motor_speed,
   output logic [7:0]       fault_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // A stopped motor reports zero speed, so no stale speed can fake sleep
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pressure    <= 16'h0000;
         motor_speed <= 16'h0000;
         fault_in    <= 8'h00;
      end else begin
         pressure    <= set_press;
         motor_speed <= motor_run ? set_speed : 16'h0000;
         fault_in    <= set_fault;
      end
   end
endmodule

//--- verif/tb_top.sv
/*
 * Self-checking bench of the pump supervisor with an APB master task.
 * Assumes a shortened one-second tick of 10 cycles and the plant model.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
   logic        run_demand, key_up, key_down, power_ok, motor_run, sleeping;
   logic        fault_hold, irq;
   logic [7:0]  paddr, set_fault, fault_in;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [15:0] pressure, motor_speed, set_press, set_speed;
   logic [13:0] countdown;
   int          n_mismatch, tests_run, n;
   wire  [3:0]  obs = {irq, fault_hold, sleeping, motor_run};
   localparam logic [7:0] RA [12] = '{sup_pkg::A_CTRL, sup_pkg::A_PRESS, sup_pkg::A_SPEED,
      sup_pkg::A_ONTIME, sup_pkg::A_DLY0, sup_pkg::A_DLY1, sup_pkg::A_DLY2, sup_pkg::A_LIM0,
      sup_pkg::A_LIM1, sup_pkg::A_LIM2, sup_pkg::A_IMASK, 8'h34};
   localparam logic [31:0] RV [12] = '{32'h1, 32'h140032, 32'hA001E, 32'h1E001E, 32'h3C0004,
      32'hF000F, 32'h30000, 32'hA0004, 32'hA000A, 32'hA000A, 32'h0, 32'h0};

   pump_supervisor #(.TICK_CYCLES(10)) uut (.sys_clk(sys_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pressure(pressure),
      .motor_speed(motor_speed), .fault_in(fault_in), .run_demand(run_demand),
      .key_up(key_up), .key_down(key_down), .power_ok(power_ok), .motor_run(motor_run),
      .sleeping(sleeping), .fault_hold(fault_hold), .countdown(countdown), .irq(irq));
   pump_plant plant (.sys_clk(sys_clk), .resetn(resetn), .motor_run(motor_run),
      .set_press(set_press), .set_speed(set_speed), .set_fault(set_fault),
      .pressure(pressure), .motor_speed(motor_speed), .fault_in(fault_in));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Speed just under the sleep threshold: offset plus lowest run speed
   function automatic logic [15:0] low_speed(input logic [15:0] off, input logic [15:0] lo);
      return off + lo - 16'h0001 - {14'h0, seed[1:0]};
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic hang;
      n_mismatch++;
      report_and_stop;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) hang;
   endtask
   // Outputs are sampled at the falling edge, where they have settled
   task automatic wait_hi(input int i, input int lim);
      n = 0;
      @(negedge sys_clk);
      while (obs[i] !== 1'b1) begin
         if (n >= lim) hang;
         @(negedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
   endtask
   task automatic see(input string nm, input int i, input logic v);
      @(negedge sys_clk);
      chk(nm, {31'h0, obs[i]}, {31'h0, v});
      @(posedge sys_clk);
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic fault(input logic [7:0] f);
      set_fault <= f;
      wait_hi(2, 30);
      set_fault <= 8'h00;
   endtask
   task automatic power_cycle;
      power_ok <= 1'b0;
      idle(5);
      power_ok <= 1'b1;
      idle(5);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {resetn, psel, penable, pwrite, key_up, key_down} = 6'h00;
      {run_demand, power_ok} = 2'h3;
      {paddr, pwdata, set_fault} = 48'h0;
      {set_press, set_speed} = {16'h0028, 16'h0032};
      seed = 32'h0000_002D;
      n_mismatch = 0;
      tests_run = 0;
      idle(12);
      resetn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, RA[i], 32'h0);
         chk("reset_value", rd, RV[i]);
         chk("slverr", {31'h0, er}, {31'h0, i == 11});
      end
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         apb(1'b1, sup_pkg::A_LIM1, seed & 32'h3FFF_3FFF);
         apb(1'b0, sup_pkg::A_LIM1, 32'h0);
         chk("lim1_rw", rd, seed & 32'h3FFF_3FFF);
      end
      apb(1'b1, sup_pkg::A_ONTIME, 32'h0002_0002);
      wait_hi(0, 60);
      $display("test reset done");
      apb(1'b1, sup_pkg::A_CTRL, 32'h201);
      see("stopped", 0, 1'b0);
      apb(1'b1, sup_pkg::A_CTRL, 32'h101);
      apb(1'b0, sup_pkg::A_STATUS, 32'h0);
      chk("short_state", rd[6:0], sup_pkg::S_SHORT);
      chk("short_count", rd[21:8] >= 2 && rd[21:8] <= 3, 1);
      wait_hi(0, 60);
      chk("short_time", n >= 10, 1);
      apb(1'b1, sup_pkg::A_CTRL, 32'h201);
      apb(1'b1, sup_pkg::A_CTRL, 32'h101);
      key_up <= 1'b1;
      key_down <= 1'b1;
      idle(4);
      {key_up, key_down} <= 2'h0;
      wait_hi(0, 8);
      // Back to auto mode, or a sleeping pump would never wake
      power_cycle;
      wait_hi(0, 60);
      $display("test short_cycle done");
      set_press <= 16'h0032 + 16'h0014 + 16'h0001;
      idle(8);
      see("overp_cfg0", 1, 1'b0);
      apb(1'b1, sup_pkg::A_CTRL, 32'h5);
      wait_hi(1, 6);
      see("overp_stop", 0, 1'b0);
      apb(1'b0, sup_pkg::A_ISTAT, 32'h0);
      chk("istat", rd & 32'hC, 32'hC);
      apb(1'b1, sup_pkg::A_IMASK, 32'h8);
      see("irq_on", 3, 1'b1);
      apb(1'b1, sup_pkg::A_ISTAT, 32'hF);
      see("irq_off", 3, 1'b0);
      set_press <= 16'h0028;
      wait_hi(0, 60);
      $display("test overpressure done");
      seed = xs(seed);
      set_press <= 16'h002D;
      set_speed <= low_speed(16'h000A, 16'h001E);
      idle(40);
      see("low_press", 1, 1'b0);
      set_press <= 16'h0032;
      set_speed <= 16'h0028;
      idle(10);
      see("fast", 1, 1'b0);
      set_speed <= low_speed(16'h000A, 16'h001E);
      wait_hi(1, 20);
      set_press <= 16'h0028;
      wait_hi(0, 60);
      set_press <= 16'h0032;
      wait_hi(1, 40);
      chk("on_time", n >= 10, 1);
      set_press <= 16'h0028;
      wait_hi(0, 60);
      apb(1'b1, sup_pkg::A_SPEED, 32'h0000_001E);
      set_press <= 16'h0032;
      set_speed <= 16'h001E;
      idle(60);
      see("no_sleep", 1, 1'b0);
      see("keeps_run", 0, 1'b1);
      apb(1'b1, sup_pkg::A_CTRL, 32'h1);
      $display("test sleep done");
      apb(1'b1, sup_pkg::A_DLY0, 32'h0002_0002);
      apb(1'b1, sup_pkg::A_LIM0, 32'h000A_0001);
      fault(8'h01);
      wait_hi(0, 80);
      chk("restart_wait", n >= 10, 1);
      fault(8'h01);
      apb(1'b0, sup_pkg::A_STATUS, 32'h0);
      chk("lock", rd[6:0], sup_pkg::S_LOCK);
      idle(60);
      see("lock_hold", 2, 1'b1);
      run_demand <= 1'b0;
      apb(1'b1, sup_pkg::A_CTRL, 32'h401);
      apb(1'b0, sup_pkg::A_STATUS, 32'h0);
      chk("cleared", rd[6:0], sup_pkg::S_OFF);
      run_demand <= 1'b1;
      wait_hi(0, 60);
      fault(8'h01);
      apb(1'b0, sup_pkg::A_STATUS, 32'h0);
      chk("fresh_count", rd[6:0], sup_pkg::S_TRIP);
      wait_hi(0, 80);
      set_fault <= 8'h04;
      idle(8);
      see("dry_early", 2, 1'b0);
      fault(8'h04);
      wait_hi(0, 220);
      $display("test faults done");
      apb(1'b1, sup_pkg::A_DLY2, 32'h0003_0002);
      power_cycle;
      apb(1'b0, sup_pkg::A_STATUS, 32'h0);
      chk("startup", rd[6:0], sup_pkg::S_START);
      wait_hi(0, 90);
      chk("startup_time", n >= 10, 1);
      apb(1'b1, sup_pkg::A_CTRL, 32'h0);
      power_cycle;
      idle(30);
      apb(1'b0, sup_pkg::A_STATUS, 32'h0);
      chk("init_off", rd[7:0], {1'b0, sup_pkg::S_OFF});
      see("off_idle", 0, 1'b0);
      $display("test power done");
      report_and_stop;
   end
endmodule
